// ==== test/ars_breaker_model.sv ====
`timescale 1ns/1ps
// breaker objects: each follows its open and close commands after DLY+1 cycles
module ars_breaker_model import ars_pkg::*; #(
  parameter int DLY = 3
) (
  mclk,
  rst,
  cmd,
  objOpen,
  objClosed
);
  input wire logic mclk;
  input wire logic rst;
  input wire ars_cmd_t cmd;
  output logic [4:0] objOpen;
  output logic [4:0] objClosed;
  logic [DLY*5-1:0] opPipe;
  logic [DLY*5-1:0] clPipe;
  logic [4:0] nowOpen;
  // delayed command decides the new position; status is never unknown
  assign nowOpen = (objOpen | opPipe[DLY*5-1 -: 5]) & ~clPipe[DLY*5-1 -: 5];
  // command pipes and reported position, all closed after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      opPipe <= '0;
      clPipe <= '0;
      objOpen <= 5'h00;
      objClosed <= 5'h1F;
    end else begin
      opPipe <= {opPipe[DLY*5-6:0], cmd.openCmd};
      clPipe <= {clPipe[DLY*5-6:0], cmd.closeCmd};
      objOpen <= nowOpen;
      objClosed <= ~nowOpen;
    end
  end
endmodule // ars_breaker_model

// ==== test/test_ars_shot_sequencer.sv ====
`timescale 1ns/1ps
module test_ars_shot_sequencer;
  import ars_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] address = 13'h0000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [4:0] req = 5'h00;
  logic [4:0] reqTrip = 5'h00;
  logic onOff = 1'b0;
  logic blockIn = 1'b0;
  logic lockIn = 1'b0;
  logic manRst = 1'b0;
  logic anyClose = 1'b0;
  logic manClose = 1'b0;
  logic grp = 1'b0;
  logic [4:0] objOpen;
  logic [4:0] objClosed;
  ars_pins_t pins;
  ars_cmd_t cmd;
  logic readyOut, lockedOut, inhibitOut, runningOut;
  logic [31:0] q;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  assign pins = {req, reqTrip, onOff, blockIn, lockIn, manRst, anyClose,
                 manClose, objOpen, objClosed, grp};
  ars_shot_sequencer #(.TICK_CYCLES_P(4)) dut (.mclk(mclk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .pinsIn(pins),
    .cmdOut(cmd), .readyOut(readyOut), .lockedOut(lockedOut),
    .inhibitOut(inhibitOut), .runningOut(runningOut));
  ars_breaker_model brk (.mclk(mclk), .rst(rst), .cmd(cmd),
    .objOpen(objOpen), .objClosed(objClosed));
  // clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return cmd.openCmd[0];
      1: return cmd.closeCmd[0];
      2: return cmd.finalTrip;
      3: return readyOut;
      4: return lockedOut;
      default: return inhibitOut;
    endcase
  endfunction
  // waits up to lim cycles for an output and judges whether it came
  task automatic see(input int k, input int lim, input logic exp);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge mclk);
      #1;
      hit = (sig(k) === 1'b1);
    end
    chk(32'(hit), 32'(exp));
  endtask
  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [12:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  function automatic logic [12:0] sa(input int r, input int s, input int f);
    return 13'(32'h1000 + r * 256 + s * 32 + f * 4);
  endfunction
  task automatic t_reset();
    see(5, 2, 1);
    bus(0, 13'h0100, 0);
    chk(q, 32'(CFG_RST));
    bus(0, 13'h0000, 0);
    chk(q, 32'h0);
    bus(0, 13'h0108, 0);
    chk(q, 32'(CLOSE_RECL_RST));
  endtask
  // group 0: enabled, object 1; request 1 two shots, request 3 shot 2 only
  task automatic t_setup();
    bus(1, 13'h0100, 32'h1);
    bus(1, sa(0, 0, 0), 32'h80000000);
    bus(1, sa(0, 0, 1), 2);
    bus(1, sa(0, 0, 2), 3);
    bus(1, sa(0, 0, 4), 6);
    bus(1, sa(0, 1, 0), 32'h80000000);
    bus(1, sa(0, 1, 1), 0);
    bus(1, sa(0, 1, 2), 2);
    bus(1, sa(0, 1, 4), 6);
    bus(1, sa(1, 0, 0), 32'h80000000);
    bus(1, sa(1, 0, 1), 2);
    bus(1, sa(2, 1, 0), 32'h80000000);
    see(3, 100, 1);
  endtask
  task automatic t_success();
    @(posedge mclk) req <= 5'h01;
    see(0, 10, 0);
    see(0, 200, 1);
    chk(runningOut, 1);
    @(posedge mclk) req <= 5'h00;
    see(1, 15, 0);
    see(1, 200, 1);
    see(3, 200, 1);
  endtask
  task automatic t_skip();
    @(posedge mclk) req <= 5'h04;
    see(0, 100, 1);
    @(posedge mclk) req <= 5'h00;
    see(1, 200, 1);
    see(3, 200, 1);
  endtask
  task automatic t_refuse();
    @(posedge mclk) reqTrip <= 5'h02;
    req <= 5'h02;
    see(0, 60, 0);
    chk(readyOut, 1);
    @(posedge mclk) req <= 5'h00;
    reqTrip <= 5'h00;
    @(posedge mclk) req <= 5'h08;
    see(0, 60, 0);
    @(posedge mclk) req <= 5'h00;
    see(3, 50, 1);
  endtask
  task automatic t_fail();
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk) req <= 5'h01;
      see(0, 200, 1);
      @(posedge mclk) req <= 5'h00;
      see(1, 200, 1);
      repeat (12) @(posedge mclk);
    end
    req <= 5'h01;
    see(2, 100, 1);
    see(4, 20, 1);
    @(posedge mclk) req <= 5'h00;
    manRst <= 1'b1;
    see(3, 100, 1);
    @(posedge mclk) manRst <= 1'b0;
  endtask
  task automatic t_inhibit();
    @(posedge mclk) grp <= 1'b1;
    see(5, 20, 1);
    @(posedge mclk) grp <= 1'b0;
    see(3, 20, 1);
    @(posedge mclk) blockIn <= 1'b1;
    see(5, 20, 1);
    @(posedge mclk) blockIn <= 1'b0;
    see(3, 20, 1);
  endtask
  // arcing: request during action time opens and locks
  task automatic t_arc();
    bus(1, sa(0, 0, 3), 4);
    @(posedge mclk) req <= 5'h01;
    see(0, 200, 1);
    @(posedge mclk) req <= 5'h00;
    see(1, 200, 1);
    repeat (12) @(posedge mclk);
    req <= 5'h01;
    see(0, 30, 1);
    chk(lockedOut, 1);
    @(posedge mclk) req <= 5'h00;
    manRst <= 1'b1;
    see(3, 100, 1);
    @(posedge mclk) manRst <= 1'b0;
    bus(1, sa(0, 0, 3), 0);
  endtask
  // request while the lock-out timer runs
  task automatic t_lockout();
    bus(1, 13'h0104, 30);
    @(posedge mclk) req <= 5'h01;
    see(0, 200, 1);
    @(posedge mclk) req <= 5'h00;
    see(1, 200, 1);
    repeat (40) @(posedge mclk);
    req <= 5'h01;
    see(0, 30, 1);
    chk(lockedOut, 1);
    @(posedge mclk) req <= 5'h00;
    manRst <= 1'b1;
    see(3, 100, 1);
    @(posedge mclk) manRst <= 1'b0;
    bus(1, 13'h0104, 0);
  endtask
  // close reclaim, release by close command, on/off signal
  task automatic t_reclaim();
    bus(1, 13'h0108, 40);
    bus(1, 13'h0100, 32'h11);
    @(posedge mclk) manClose <= 1'b1;
    see(5, 20, 1);
    @(posedge mclk) req <= 5'h01;
    see(4, 20, 1);
    see(0, 10, 0);
    @(posedge mclk) req <= 5'h00;
    manClose <= 1'b0;
    anyClose <= 1'b1;
    see(3, 300, 1);
    @(posedge mclk) anyClose <= 1'b0;
    see(3, 300, 1);
    bus(1, 13'h0008, 1);
    see(5, 20, 1);
    @(posedge mclk) onOff <= 1'b1;
    see(3, 20, 1);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_success();
    t_skip();
    t_refuse();
    t_fail();
    t_inhibit();
    t_arc();
    t_lockout();
    t_reclaim();
    conclude();
  end
endmodule // test_ars_shot_sequencer

// ==== verilog/ars_pkg.sv ====
package ars_pkg;
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 500;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TW = 22;
  localparam int NREQ = 5;
  localparam int NSHOT = 5;
  localparam int NGRP = 2;
  localparam int NSLOT = NGRP * NREQ * NSHOT;
  localparam int AW = 13;
  localparam logic [2:0] SHOT_NONE = 3'h5;
  localparam int CLOSE_RECL_MS = 10000;
  localparam logic [TW-1:0] CLOSE_RECL_RST =
    TW'(CLOSE_RECL_MS * 1000 / TICK_US);
  // address decode: bits 12:8 select the area, word field in low bits
  localparam logic [4:0] AREA_GLOB = 5'h00;
  localparam logic [4:0] AREA_GEN = 5'h01;
  localparam int SHOT_AREA_BIT = 12;
  localparam logic [1:0] GL_STATUS = 2'h0;
  localparam logic [1:0] GL_TIMER = 2'h1;
  localparam logic [1:0] GL_CONFIG = 2'h2;
  localparam logic [1:0] GF_CFG = 2'h0;
  localparam logic [1:0] GF_LOCKOUT = 2'h1;
  localparam logic [1:0] GF_CLRECL = 2'h2;
  localparam logic [2:0] SF_CTRL = 3'h0;
  localparam logic [2:0] SF_START = 3'h1;
  localparam logic [2:0] SF_DEAD = 3'h2;
  localparam logic [2:0] SF_ACT = 3'h3;
  localparam logic [2:0] SF_RECL = 3'h4;
  // field positions
  localparam int CFG_EN = 0;
  localparam int CFG_OBJ = 1;
  localparam int CFG_MODE = 4;
  localparam int CFG_GENSEL = 5;
  localparam int CFG_W = 6;
  localparam int GLB_ONOFF = 0;
  localparam int SHOT_EN = 31;
  localparam int SHOT_DISCR = 30;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;

  typedef enum logic [3:0] {
    S_INHIBIT, S_READY, S_START, S_OPEN, S_DEAD, S_CLOSE,
    S_ACTION, S_RECLAIM, S_LOCKOUT, S_LOCKED
  } ars_state_t;

  typedef struct packed {
    logic [NREQ-1:0] req;
    logic [NREQ-1:0] reqTrip;
    logic onOff;
    logic blockIn;
    logic lockIn;
    logic manRst;
    logic anyClose;
    logic manClose;
    logic [4:0] objOpen;
    logic [4:0] objClosed;
    logic group;
  } ars_pins_t;

  typedef struct packed {
    logic [4:0] openCmd;
    logic [4:0] closeCmd;
    logic finalTrip;
  } ars_cmd_t;

  localparam int PIN_W = $bits(ars_pins_t);
endpackage

// ==== verilog/ars_shot_sequencer.sv ====
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module ars_shot_sequencer import ars_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire ars_pins_t pinsIn,
  output ars_cmd_t cmdOut,
  output logic readyOut,
  output logic lockedOut,
  output logic inhibitOut,
  output logic runningOut
);
  ars_pins_t pins;
  ars_pins_t pinsPrev_reg;
  logic tick;
  logic useOnOff_reg;
  logic [CFG_W-1:0] genCfg_reg [NGRP];
  logic [TW-1:0] lockoutT_reg [NGRP];
  logic [TW-1:0] closeReclT_reg [NGRP];
  logic [1:0] shotCtl_reg [NSLOT];
  logic [TW-1:0] startT_reg [NSLOT];
  logic [TW-1:0] deadT_reg [NSLOT];
  logic [TW-1:0] actT_reg [NSLOT];
  logic [TW-1:0] reclT_reg [NSLOT];
  ars_state_t state_reg;
  ars_state_t state_next;
  logic [2:0] curReq_reg;
  logic [2:0] curReq_next;
  logic [2:0] curShot_reg;
  logic [2:0] curShot_next;
  logic arcHit_reg;
  logic arcHit_next;
  logic [TW-1:0] elapsed_reg;
  logic [TW-1:0] genElapsed_reg;
  logic genActive_reg;
  logic [TW-1:0] limit;
  logic timerDone;
  logic genRun;
  logic genStart;
  logic openP;
  logic closeP;
  logic tripP;
  logic doAdvance;
  logic grp;
  logic [CFG_W-1:0] cfg;
  logic enabled;
  logic [4:0] objMask;
  logic objOpenSel;
  logic objClosedSel;
  logic inhibitCause;
  logic reqAny;
  logic reqRise;
  logic lockRelease;
  logic [2:0] firstReq;
  logic [2:0] firstShot;
  logic [2:0] advShot;
  logic [5:0] cur;
  logic tripRefuse;
  logic [31:0] rdValue;
  logic wrEn;
  logic [5:0] wSlot;
  logic wShotOk;

  ars_tick_gen #(.CYCLES(TICK_CYCLES_P)) uTick (
    .mclk(mclk),
    .rst(rst),
    .tick(tick)
  );

  ars_sync #(.W(PIN_W)) uSync (
    .mclk(mclk),
    .rst(rst),
    .din(pinsIn),
    .dout(pins)
  );

  // flat index of one shot slot
  function automatic logic [5:0] slotIdx(input logic g,
                                         input logic [2:0] r,
                                         input logic [2:0] s);
    return 6'(32'(g) * NREQ * NSHOT + 32'(r) * NSHOT + 32'(s));
  endfunction

  // first enabled shot at or after a start point
  function automatic logic [2:0] nextShot(input logic g,
                                          input logic [2:0] r,
                                          input logic [3:0] from);
    logic [2:0] res;
    res = SHOT_NONE;
    for (int s = NSHOT - 1; s >= 0; s--) begin
      if (4'(s) >= from && shotCtl_reg[slotIdx(g, r, 3'(s))][1]) begin
        res = 3'(s);
      end
    end
    return res;
  endfunction

  // live settings of the active group and current shot
  always_comb begin
    grp = pins.group;
    cfg = genCfg_reg[grp];
    enabled = cfg[CFG_EN] && (!useOnOff_reg || pins.onOff);
    objMask = 5'h01 << cfg[CFG_OBJ +: 3];
    objOpenSel = |(pins.objOpen & objMask);
    objClosedSel = |(pins.objClosed & objMask);
    reqAny = |pins.req;
    reqRise = reqAny && !(|pinsPrev_reg.req);
    lockRelease = (pins.manRst && !pinsPrev_reg.manRst) ||
      (cfg[CFG_MODE] && pins.anyClose && !pinsPrev_reg.anyClose);
    firstReq = 3'h0;
    for (int r = NREQ - 1; r >= 0; r--) begin
      if (pins.req[r]) begin
        firstReq = 3'(r);
      end
    end
    firstShot = nextShot(grp, firstReq, 4'h0);
    tripRefuse = pins.reqTrip[firstReq] && firstShot != SHOT_NONE &&
      startT_reg[slotIdx(grp, firstReq, firstShot)] != '0;
    advShot = nextShot(grp, curReq_reg, 4'(curShot_reg) + 4'h1);
    cur = slotIdx(grp, curReq_reg, curShot_reg);
    genRun = genActive_reg && genElapsed_reg < closeReclT_reg[grp];
    inhibitCause = !enabled || pins.blockIn || genRun ||
      (objOpenSel == objClosedSel);
  end

  // time limit of the running phase, read live
  always_comb begin
    case (state_reg)
      S_START: limit = startT_reg[cur];
      S_DEAD: limit = deadT_reg[cur];
      S_ACTION: limit = actT_reg[cur];
      S_RECLAIM: limit = reclT_reg[cur];
      S_LOCKOUT: limit = lockoutT_reg[grp];
      default: limit = '0;
    endcase
    timerDone = elapsed_reg >= limit;
  end

  // sequence control
  always_comb begin
    state_next = state_reg;
    curReq_next = curReq_reg;
    curShot_next = curShot_reg;
    arcHit_next = arcHit_reg;
    openP = 1'b0;
    closeP = 1'b0;
    tripP = 1'b0;
    genStart = 1'b0;
    doAdvance = 1'b0;
    case (state_reg)
      S_READY, S_INHIBIT: begin
        if (genRun && reqRise) begin
          state_next = S_LOCKED;
        end else if (inhibitCause) begin
          state_next = S_INHIBIT;
        end else if (reqAny && firstShot != SHOT_NONE && !tripRefuse) begin
          curReq_next = firstReq;
          curShot_next = firstShot;
          state_next = S_START;
        end else begin
          state_next = S_READY;
        end
      end
      S_START: begin
        if (!pins.req[curReq_reg]) begin
          state_next = S_READY;
        end else if (timerDone) begin
          openP = 1'b1;
          state_next = S_OPEN;
        end
      end
      S_OPEN: begin
        if (objOpenSel) begin
          state_next = S_DEAD;
        end
      end
      S_DEAD: begin
        if (timerDone) begin
          closeP = 1'b1;
          state_next = S_CLOSE;
        end
      end
      S_CLOSE: begin
        arcHit_next = 1'b0;
        if (objClosedSel) begin
          state_next = (actT_reg[cur] == '0) ? S_RECLAIM : S_ACTION;
        end
      end
      S_ACTION: begin
        if (reqRise && shotCtl_reg[cur][0]) begin
          doAdvance = 1'b1; // discrimination ends the shot at once
        end else if (timerDone) begin
          if (arcHit_reg || reqRise) begin
            openP = 1'b1;
            state_next = S_LOCKED;
          end else begin
            state_next = S_RECLAIM;
          end
        end else if (reqRise) begin
          arcHit_next = 1'b1;
        end
      end
      S_RECLAIM: begin
        if (reqRise) begin
          doAdvance = 1'b1;
        end else if (timerDone) begin
          genStart = cfg[CFG_GENSEL];
          state_next = (lockoutT_reg[grp] == '0) ? S_READY : S_LOCKOUT;
        end
      end
      S_LOCKOUT: begin
        if (reqRise) begin
          openP = 1'b1;
          state_next = S_LOCKED;
        end else if (timerDone) begin
          state_next = S_READY;
        end
      end
      S_LOCKED: begin
        if (lockRelease) begin
          state_next = S_READY;
        end
      end
      default: state_next = S_INHIBIT;
    endcase
    if (doAdvance) begin
      if (advShot == SHOT_NONE) begin
        tripP = 1'b1;
        openP = 1'b1;
        state_next = S_LOCKED;
      end else begin
        curShot_next = advShot;
        state_next = S_START;
      end
    end
    if (pins.lockIn) begin
      state_next = S_LOCKED;
    end else if (!enabled &&
                 (state_reg != S_LOCKED || state_next != S_LOCKED)) begin
      state_next = S_INHIBIT;
      openP = 1'b0; // a disabled sequencer gives no commands while lockIn is low
      closeP = 1'b0;
      tripP = 1'b0;
      genStart = 1'b0;
    end
  end

  // state, shot position and status outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= S_INHIBIT;
      curReq_reg <= 3'h0;
      curShot_reg <= 3'h0;
      arcHit_reg <= 1'b0;
      pinsPrev_reg <= '0;
      readyOut <= 1'b0;
      lockedOut <= 1'b0;
      inhibitOut <= 1'b1;
      runningOut <= 1'b0;
    end else begin
      state_reg <= state_next;
      curReq_reg <= curReq_next;
      curShot_reg <= curShot_next;
      arcHit_reg <= arcHit_next;
      pinsPrev_reg <= pins;
      readyOut <= state_next == S_READY;
      lockedOut <= state_next == S_LOCKED;
      inhibitOut <= state_next == S_INHIBIT;
      runningOut <= state_next inside {S_START, S_OPEN, S_DEAD, S_CLOSE,
                                       S_ACTION, S_RECLAIM};
    end
  end

  // breaker command pulses on the selected object
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmdOut <= '0;
    end else begin
      cmdOut.openCmd <= openP ? objMask : 5'h00;
      cmdOut.closeCmd <= closeP ? objMask : 5'h00;
      cmdOut.finalTrip <= tripP;
    end
  end

  // phase timer, restarted at every state change
  always_ff @(posedge mclk) begin
    if (rst || state_next != state_reg) begin
      elapsed_reg <= '0;
    end else if (tick && !timerDone) begin
      elapsed_reg <= elapsed_reg + 1'b1;
    end
  end

  // object close reclaim timer
  always_ff @(posedge mclk) begin
    if (rst) begin
      genActive_reg <= 1'b0;
      genElapsed_reg <= '0;
    end else if (genStart || (pins.manClose && !pinsPrev_reg.manClose)) begin
      genActive_reg <= 1'b1;
      genElapsed_reg <= '0;
    end else if (!genRun) begin
      genActive_reg <= 1'b0;
    end else if (tick) begin
      genElapsed_reg <= genElapsed_reg + 1'b1;
    end
  end

  // bus decode and read data
  always_comb begin
    wShotOk = address[10:8] < 3'(NREQ) && address[7:5] < 3'(NSHOT);
    wSlot = slotIdx(address[11], address[10:8], address[7:5]);
    wrEn = write && !waitrequest;
    rdValue = 32'h0000_0000;
    if (address[SHOT_AREA_BIT]) begin
      if (wShotOk) begin
        case (address[4:2])
          SF_CTRL: begin
            rdValue[SHOT_EN] = shotCtl_reg[wSlot][1];
            rdValue[SHOT_DISCR] = shotCtl_reg[wSlot][0];
          end
          SF_START: rdValue = 32'(startT_reg[wSlot]);
          SF_DEAD: rdValue = 32'(deadT_reg[wSlot]);
          SF_ACT: rdValue = 32'(actT_reg[wSlot]);
          SF_RECL: rdValue = 32'(reclT_reg[wSlot]);
          default: rdValue = 32'h0000_0000;
        endcase
      end
    end else if (address[11:8] == AREA_GEN[3:0]) begin
      case (address[3:2])
        GF_CFG: rdValue = 32'(genCfg_reg[address[4]]);
        GF_LOCKOUT: rdValue = 32'(lockoutT_reg[address[4]]);
        GF_CLRECL: rdValue = 32'(closeReclT_reg[address[4]]);
        default: rdValue = 32'h0000_0000;
      endcase
    end else if (address[11:8] == AREA_GLOB[3:0]) begin
      case (address[3:2])
        GL_STATUS: rdValue = {19'h0, genRun, curReq_reg, curShot_reg,
                              arcHit_reg, 1'b0, 4'(state_reg)};
        GL_TIMER: rdValue = 32'(elapsed_reg);
        GL_CONFIG: rdValue = 32'(useOnOff_reg);
        default: rdValue = 32'h0000_0000;
      endcase
    end
  end

  // avalon slave handshake: one wait cycle per access
  always_ff @(posedge mclk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata <= read ? rdValue : 32'h0000_0000;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // settings storage written over the bus
  always_ff @(posedge mclk) begin
    if (rst) begin
      useOnOff_reg <= 1'b0;
      for (int i = 0; i < NGRP; i++) begin
        genCfg_reg[i] <= CFG_RST;
        lockoutT_reg[i] <= '0;
        closeReclT_reg[i] <= CLOSE_RECL_RST;
      end
      for (int i = 0; i < NSLOT; i++) begin
        shotCtl_reg[i] <= 2'h0;
        startT_reg[i] <= '0;
        deadT_reg[i] <= '0;
        actT_reg[i] <= '0;
        reclT_reg[i] <= '0;
      end
    end else if (wrEn) begin
      if (address[SHOT_AREA_BIT]) begin
        if (wShotOk) begin
          case (address[4:2])
            SF_CTRL: shotCtl_reg[wSlot] <= {writedata[SHOT_EN],
                                            writedata[SHOT_DISCR]};
            SF_START: startT_reg[wSlot] <= writedata[TW-1:0];
            SF_DEAD: deadT_reg[wSlot] <= writedata[TW-1:0];
            SF_ACT: actT_reg[wSlot] <= writedata[TW-1:0];
            SF_RECL: reclT_reg[wSlot] <= writedata[TW-1:0];
            default: ;
          endcase
        end
      end else if (address[11:8] == AREA_GEN[3:0]) begin
        case (address[3:2])
          GF_CFG: genCfg_reg[address[4]] <= writedata[CFG_W-1:0];
          GF_LOCKOUT: lockoutT_reg[address[4]] <= writedata[TW-1:0];
          GF_CLRECL: closeReclT_reg[address[4]] <= writedata[TW-1:0];
          default: ;
        endcase
      end else if (address[11:8] == AREA_GLOB[3:0] &&
                   address[3:2] == GL_CONFIG) begin
        useOnOff_reg <= writedata[GLB_ONOFF];
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sDeadEnd;
    state_reg == S_DEAD && timerDone && enabled && !pins.lockIn;
  endsequence
  sequence sCloseIssued;
    (|cmdOut.closeCmd) && state_reg == S_CLOSE;
  endsequence

  a_obj_select:
    assert property (cmdOut.openCmd == 5'h00 ||
                     $onehot(cmdOut.openCmd))
      else $error("open command not one-hot");
  a_disabled_inhibit:
    assert property (!enabled && !pins.lockIn && state_reg != S_LOCKED
                     |=> state_reg == S_INHIBIT)
      else $error("disabled sequencer not in inhibit");
  a_lock_release:
    assert property (state_reg == S_LOCKED && lockRelease && !pins.lockIn
                     && enabled |=> state_reg == S_READY)
      else $error("lock not released");
  a_lockout_zero:
    assert property (state_reg == S_RECLAIM && timerDone && !reqRise &&
                     enabled && !pins.lockIn && lockoutT_reg[grp] == '0
                     |=> state_reg == S_READY)
      else $error("zero lock-out did not return to ready");
  a_lockout_request:
    assert property (state_reg == S_LOCKOUT && reqRise && !pins.lockIn
                     && enabled
                     |=> state_reg == S_LOCKED ##1 $past(|cmdOut.openCmd))
      else $error("request in lock-out not locked with open");
  a_general_reclaim:
    assert property (state_reg inside {S_READY, S_INHIBIT} && genRun &&
                     reqRise && !pins.lockIn && enabled
                     |=> state_reg == S_LOCKED && cmdOut.openCmd == 5'h00)
      else $error("request in close reclaim not locked");
  a_dead_close:
    assert property (sDeadEnd |=> sCloseIssued)
      else $error("dead time end gave no close");
  a_final_trip:
    assert property (state_reg == S_RECLAIM && reqRise &&
                     advShot == SHOT_NONE && !pins.lockIn && enabled
                     |=> cmdOut.finalTrip && state_reg == S_LOCKED)
      else $error("no final trip after last shot");
  a_start_drop:
    assert property (state_reg == S_START && !pins.req[curReq_reg] &&
                     !pins.lockIn && enabled
                     |=> cmdOut.openCmd == 5'h00 && state_reg != S_OPEN)
      else $error("dropped request still opened");
endmodule // ars_shot_sequencer

// ==== verilog/ars_sync.sv ====
`timescale 1ns/1ps
module ars_sync import ars_pkg::*; #(
  parameter int W = PIN_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // three stages; a bit counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // ars_sync

// ==== verilog/ars_tick_gen.sv ====
`timescale 1ns/1ps
module ars_tick_gen import ars_pkg::*; #(
  parameter int CYCLES = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  logic [CW-1:0] count_reg;

  // one-cycle enable every timer tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (count_reg == CW'(CYCLES - 1)) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // ars_tick_gen
